// ---- include/sbsc_pkg.sv ----
/*
  sbsc_pkg: register offsets, field positions, reset values and timing counts
  for the bus control line block. Assumes an APB slave with 32-bit data.
*/
// Notes on behaviour
// - sample register reads live CD IO MSG ATN SEL BSY REQ ACK, bits 7..0.
// - sample and drive registers share one address; read samples, write drives.
// - only lines meaningful in the current mode reach the bus.
// - initiator mode compares upper three drive bits against bus phase lines.
// - drive register clears on chip reset, bus reset and bus free.
// - CD IO MSG drive in target and SCAM; expected phase in initiator.
// - ATN set by writing one in initiator; cleared by attention clear, chip reset, bus reset or bus free.
// - SEL drive bit asserts or negates SEL, also in SCAM mode.
// - BSY drive bit drives BSY; LED lit when set and diag LED off.
// - REQ drive bit drives REQ in target and SCAM, not initiator.
// - ACK drive bit drives ACK in initiator, not target.
// - offset zero disables synchronous transfers; nonzero enables with that offset.
// - rate register: wide bit 7, rate select 6..4, offset 3..0.
// - wide transfers only when wide bit and wide bus select both set.
// - REQ/ACK period is four plus rate code cycles, width two cycles.
`default_nettype none
package sbsc_pkg;
  // register indices; the bus byte address is four times the index
  localparam int          IDX_SIGNAL      = 3;
  localparam int          IDX_RATE        = 4;
  localparam logic [11:0] ADDR_SIGNAL     = 12'(4 * IDX_SIGNAL);
  localparam logic [11:0] ADDR_RATE       = 12'(4 * IDX_RATE);
  localparam logic [11:0] ADDR_INTCLR     = 12'h014;
  localparam logic [11:0] ADDR_BLKCTL     = 12'h018;
  localparam logic [11:0] ADDR_MODE       = 12'h01c;
  localparam int          BIT_CD          = 7;
  localparam int          BIT_IO          = 6;
  localparam int          BIT_MSG         = 5;
  localparam int          BIT_ATN         = 4;
  localparam int          BIT_SEL         = 3;
  localparam int          BIT_BSY         = 2;
  localparam int          BIT_REQ         = 1;
  localparam int          BIT_ACK         = 0;
  localparam int          BIT_WIDE        = 7;
  localparam int          BIT_ATN_CLEAR   = 6;
  localparam int          BIT_WIDE_SEL    = 1;
  localparam int          BIT_DIAG_LED    = 7;
  localparam logic [7:0]  RST_DRIVE       = 8'h00;
  localparam logic [7:0]  RST_RATE        = 8'h00;
  localparam logic [1:0]  RST_MODE        = 2'h0;
  localparam logic [7:0]  RST_BLKCTL      = 8'h00;
  localparam logic [3:0]  PERIOD_BASE     = 4'h4;
  localparam logic [3:0]  ASSERT_WIDTH    = 4'h2;
  typedef enum logic [1:0] {
    SBSC_MODE_IDLE      = 2'b00,
    SBSC_MODE_TARGET    = 2'b01,
    SBSC_MODE_INITIATOR = 2'b10,
    SBSC_MODE_SCAM      = 2'b11
  } sbsc_mode_t;
endpackage
`default_nettype wire

// ---- rtl/sbsc_sync.sv ----
/*
  sbsc_sync: three-stage synchroniser for the eight bus control lines.
  Assumes asynchronous pins; a change counts once stages two and three agree.
*/
`timescale 1ns/1ps
`default_nettype none
module sbsc_sync (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // pins and result
  input  wire logic [7:0] pin_i,
  output logic      [7:0] sync_o
);
  logic [7:0] s1_q, s2_q, s3_q, out_q;
  logic [7:0] out_d;

  always_comb
  begin
    out_d = out_q;
    for (int i = 0; i < 8; i++)
    begin
      if (s2_q[i] == s3_q[i])
      begin
        out_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q  <= 8'h00;
      s2_q  <= 8'h00;
      s3_q  <= 8'h00;
      out_q <= 8'h00;
    end
    else
    begin
      s1_q  <= pin_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_o = out_q;
endmodule // sbsc_sync
`default_nettype wire

// ---- rtl/sbsc_timing.sv ----
/*
  sbsc_timing: turns the rate select into the REQ/ACK period count; the width count is fixed.
  Assumes the rate register is stable outside transfers.
*/
`timescale 1ns/1ps
`default_nettype none
module sbsc_timing (
  // rate field
  input  wire logic [2:0] rate_sel_i,
  // derived timing
  output logic      [3:0] period_o,
  output logic      [3:0] width_o
);
  assign period_o = sbsc_pkg::PERIOD_BASE + {1'b0, rate_sel_i};
  assign width_o  = sbsc_pkg::ASSERT_WIDTH;
endmodule // sbsc_timing
`default_nettype wire

// ---- rtl/sbsc_top.sv ----
/*
  sbsc_top: APB register bank for bus control line sampling, mode-gated line
  drive and the synchronous rate and offset register.
  Assumes active-high logical bus lines at the ports; pin polarity and
  open-collector drive live in the pad ring. A driven line is asserted when
  its output bit is one.
*/
`timescale 1ns/1ps
`default_nettype none
module sbsc_top (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // bus lines sampled from pins
  input  wire logic [7:0]  bus_line_i,
  input  wire logic        bus_reset_i,
  // bus line drive, one bit per line, ordered as the sample register
  output logic      [7:0]  bus_line_o,
  output logic      [7:0]  bus_line_oe_n,
  // derived outputs
  output logic             phase_match,
  output logic             led_o,
  output logic             wide_xfer,
  output logic             sync_enable,
  output logic      [3:0]  sync_offset_max,
  output logic      [3:0]  req_ack_period,
  output logic      [3:0]  req_ack_width
);
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  logic [7:0] sample;
  logic [7:0] drive_q, drive_d;
  logic [7:0] rate_q, rate_d;
  logic [7:0] blkctl_q, blkctl_d;
  logic [1:0] mode_q, mode_d;
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d;
  logic        bus_free;
  logic        wr_en, rd_en;
  logic [7:0]  gate;
  sbsc_pkg::sbsc_mode_t mode;

  sbsc_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_i   (bus_line_i),
    .sync_o  (sample)
  );

  sbsc_timing u_timing (
    .rate_sel_i (rate_q[6:4]),
    .period_o   (req_ack_period),
    .width_o    (req_ack_width)
  );

  function automatic logic is_mapped(input logic [11:0] a);
    if (a == sbsc_pkg::ADDR_SIGNAL)
    begin
      return 1'b1;
    end
    else if (a == sbsc_pkg::ADDR_RATE)
    begin
      return 1'b1;
    end
    else if (a == sbsc_pkg::ADDR_INTCLR)
    begin
      return 1'b1;
    end
    else if (a == sbsc_pkg::ADDR_BLKCTL)
    begin
      return 1'b1;
    end
    else if (a == sbsc_pkg::ADDR_MODE)
    begin
      return 1'b1;
    end
    else
    begin
      return 1'b0;
    end
  endfunction

  // positions in the one-hot register select
  localparam int HIT_SIGNAL = 0;
  localparam int HIT_RATE   = 1;
  localparam int HIT_INTCLR = 2;
  localparam int HIT_BLKCTL = 3;
  localparam int HIT_MODE   = 4;

  logic [4:0]  wr_hit;
  logic [4:0]  rd_hit;

  // shared by the write and read paths so both always see the same map
  function automatic logic [4:0] decode_reg(input logic [11:0] a);
    logic [4:0] hit;
    hit = 5'h00;
    if (a == sbsc_pkg::ADDR_SIGNAL)
    begin
      hit[HIT_SIGNAL] = 1'b1;
    end
    else if (a == sbsc_pkg::ADDR_RATE)
    begin
      hit[HIT_RATE] = 1'b1;
    end
    else if (a == sbsc_pkg::ADDR_INTCLR)
    begin
      hit[HIT_INTCLR] = 1'b1;
    end
    else if (a == sbsc_pkg::ADDR_BLKCTL)
    begin
      hit[HIT_BLKCTL] = 1'b1;
    end
    else if (a == sbsc_pkg::ADDR_MODE)
    begin
      hit[HIT_MODE] = 1'b1;
    end
    return hit;
  endfunction

  assign mode     = sbsc_pkg::sbsc_mode_t'(mode_q);
  assign wr_en    = psel && penable && pwrite && pstrb[0];
  assign rd_en    = psel && penable && !pwrite;
  assign wr_hit   = wr_en ? decode_reg(paddr) : 5'h00;
  assign rd_hit   = decode_reg(paddr);
  // bus free: neither BSY nor SEL asserted on the synchronised lines
  assign bus_free = !sample[sbsc_pkg::BIT_BSY] && !sample[sbsc_pkg::BIT_SEL];

  // drive register
  always_comb
  begin
    drive_d = drive_q;
    if (wr_hit[HIT_SIGNAL])
    begin
      drive_d = pwdata[7:0];
      // ATN is sticky: a zero write leaves it, target mode ignores it
      if (mode == sbsc_pkg::SBSC_MODE_INITIATOR)
      begin
        drive_d[sbsc_pkg::BIT_ATN] = drive_q[sbsc_pkg::BIT_ATN] | pwdata[sbsc_pkg::BIT_ATN];
      end
      else
      begin
        drive_d[sbsc_pkg::BIT_ATN] = drive_q[sbsc_pkg::BIT_ATN];
      end
    end
    else if (wr_hit[HIT_INTCLR] && pwdata[sbsc_pkg::BIT_ATN_CLEAR])
    begin
      drive_d[sbsc_pkg::BIT_ATN] = 1'b0;
    end
    // a write racing a bus reset or bus free loses: the bus state wins
    if (bus_reset_i || bus_free)
    begin
      drive_d = sbsc_pkg::RST_DRIVE;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drive_q <= sbsc_pkg::RST_DRIVE;
    end
    else
    begin
      drive_q <= drive_d;
    end
  end

  // rate and offset register
  always_comb
  begin
    rate_d = rate_q;
    if (wr_hit[HIT_RATE])
    begin
      rate_d = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rate_q <= sbsc_pkg::RST_RATE;
    end
    else
    begin
      rate_q <= rate_d;
    end
  end

  // block control register
  always_comb
  begin
    blkctl_d = blkctl_q;
    if (wr_hit[HIT_BLKCTL])
    begin
      blkctl_d = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blkctl_q <= sbsc_pkg::RST_BLKCTL;
    end
    else
    begin
      blkctl_q <= blkctl_d;
    end
  end

  // mode register
  always_comb
  begin
    mode_d = mode_q;
    if (wr_hit[HIT_MODE])
    begin
      mode_d = pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= sbsc_pkg::RST_MODE;
    end
    else
    begin
      mode_q <= mode_d;
    end
  end

  // read data and error are taken in the setup cycle and held through access,
  // so a line moving during the access phase cannot tear the returned word
  always_comb
  begin
    rdata_d = ZERO32;
    err_d   = 1'b0;
    if (psel && !penable)
    begin
      err_d = !is_mapped(paddr);
      if (rd_hit[HIT_SIGNAL])
      begin
        rdata_d[7:0] = sample;
      end
      else if (rd_hit[HIT_RATE])
      begin
        rdata_d[7:0] = rate_q;
      end
      else if (rd_hit[HIT_BLKCTL])
      begin
        rdata_d[7:0] = blkctl_q;
      end
      else if (rd_hit[HIT_MODE])
      begin
        rdata_d[1:0] = mode_q;
      end
    end
    else if (rd_en)
    begin
      rdata_d = rdata_q;
      err_d   = err_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= ZERO32;
      err_q   <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  // per-line enable for the current mode
  always_comb
  begin
    gate = 8'h00;
    case (mode)
      sbsc_pkg::SBSC_MODE_TARGET:
      begin
        gate = 8'hee;
      end
      sbsc_pkg::SBSC_MODE_INITIATOR:
      begin
        gate = 8'h1d;
      end
      sbsc_pkg::SBSC_MODE_SCAM:
      begin
        gate = 8'hee;
      end
      default:
      begin
        gate = 8'h0c;
      end
    endcase
  end

  assign bus_line_o    = drive_q & gate;
  assign bus_line_oe_n = ~(drive_q & gate);
  // expected phase checked against the synchronised phase lines
  assign phase_match   = (mode == sbsc_pkg::SBSC_MODE_INITIATOR) &&
                         (drive_q[7:5] == sample[7:5]);
  assign led_o         = drive_q[sbsc_pkg::BIT_BSY] && !blkctl_q[sbsc_pkg::BIT_DIAG_LED];
  assign wide_xfer     = rate_q[sbsc_pkg::BIT_WIDE] && blkctl_q[sbsc_pkg::BIT_WIDE_SEL];
  assign sync_offset_max = rate_q[3:0];
  assign sync_enable   = (rate_q[3:0] != 4'h0);
  assign prdata        = rdata_q;
  assign pready        = psel && penable;
  assign pslverr       = psel && penable && err_q;
endmodule // sbsc_top
`default_nettype wire

// ---- dv/sbsc_bus_peer.sv ----
/* sbsc_bus_peer: the other bus parties seen as one wired-or load.
   Assumes active-high logical lines; the device asserts where its enable is low. */
`timescale 1ns/1ps
`default_nettype none
module sbsc_bus_peer (
  // far-side parties
  input  wire logic [7:0] peer_lines,
  // device drive
  input  wire logic [7:0] dev_oe_n,
  // resolved lines
  output logic      [7:0] wire_o
);
  // a line reads asserted while any party pulls it, so bus free needs all off
  assign wire_o = peer_lines | ~dev_oe_n;
endmodule // sbsc_bus_peer
`default_nettype wire

// ---- dv/sbsc_checker.sv ----
/* sbsc_checker: port assertions for sbsc_top.
   Assumes the bind below reaches every sbsc_top. */
`timescale 1ns/1ps
`default_nettype none
module sbsc_checker (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  // bus and derived
  input wire logic        bus_reset_i,
  input wire logic [7:0]  bus_line_o,
  input wire logic [7:0]  bus_line_oe_n,
  input wire logic        phase_match,
  input wire logic        led_o,
  input wire logic        wide_xfer,
  input wire logic        sync_enable,
  input wire logic [3:0]  sync_offset_max,
  input wire logic [3:0]  req_ack_period,
  input wire logic [3:0]  req_ack_width
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr_acc = psel && penable && pwrite;
  oe_inverse_a: assert property (bus_line_oe_n == ~bus_line_o)
    else $error("enable not inverse of drive");
  phase_gate_a: assert property (phase_match |-> bus_line_o[7:5] == 3'h0 && !bus_line_o[1])
    else $error("phase bits driven in initiator");
  reset_clear_a: assert property (bus_reset_i |=> bus_line_o == 8'h00)
    else $error("drive not cleared by bus reset");
  atn_write_a: assert property ($rose(bus_line_o[4]) |-> $past(wr_acc))
    else $error("attention rose without write");
  led_busy_a: assert property (led_o |-> bus_line_o[2])
    else $error("led without busy drive");
  sync_en_a: assert property (sync_enable == (sync_offset_max != 4'h0))
    else $error("sync enable wrong");
  rate_read_a: assert property (psel && penable && !pwrite && paddr == sbsc_pkg::ADDR_RATE |->
    prdata[3:0] == sync_offset_max && prdata[31:8] == 24'h0) else $error("rate read wrong");
  wide_set_a: assert property ($rose(wide_xfer) |-> $past(wr_acc))
    else $error("wide rose without write");
  timing_a: assert property (req_ack_width == 4'h2 && req_ack_period >= 4'h4 && req_ack_period <= 4'hb)
    else $error("timing out of range");
  cover property (phase_match);
  cover property (led_o);
  cover property (wide_xfer);
endmodule // sbsc_checker
bind sbsc_top sbsc_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .bus_reset_i,
  .bus_line_o, .bus_line_oe_n, .phase_match, .led_o, .wide_xfer, .sync_enable, .sync_offset_max,
  .req_ack_period, .req_ack_width);
`default_nettype wire

// ---- dv/tb_top.sv ----
/* tb_top: directed bench for sbsc_top with an apb master and a bus peer.
   Assumes zero-wait apb and about four edges of pin sync delay. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, bus_reset_i, pready, pslverr, err;
  logic        phase_match, led_o, wide_xfer, sync_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  bus_line_i, bus_line_o, bus_line_oe_n, peer_lines;
  logic [3:0]  sync_offset_max, req_ack_period, req_ack_width;
  int          err_count, compares;
  localparam logic [7:0] GATE [4] = '{8'h0c, 8'hee, 8'h1d, 8'hee};
  sbsc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready,
    .pslverr, .bus_line_i, .bus_reset_i, .bus_line_o, .bus_line_oe_n, .phase_match, .led_o, .wide_xfer,
    .sync_enable, .sync_offset_max, .req_ack_period, .req_ack_width);
  sbsc_bus_peer u_peer (.peer_lines, .dev_oe_n(bus_line_oe_n), .wire_o(bus_line_i));
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic final_report;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // ends on a falling edge so outputs have settled for the caller
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        err_count++;
        $display("[FAIL] %0t apb timeout", $time);
        final_report();
      end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    @(negedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic setp(input logic [7:0] v);
    @(posedge pclk);
    peer_lines <= v;
    repeat (6) @(negedge pclk);
  endtask
  task automatic t_sample;
    setp(8'h5a);
    rdchk(sbsc_pkg::ADDR_SIGNAL, 32'h5a);
    setp(8'ha5);
    rdchk(sbsc_pkg::ADDR_SIGNAL, 32'ha5);
  endtask
  task automatic t_rate;
    wr(sbsc_pkg::ADDR_RATE, 32'hffff_ffb5);
    rdchk(sbsc_pkg::ADDR_RATE, 32'hb5);
    chk({sync_enable, wide_xfer, sync_offset_max, req_ack_period, req_ack_width}, 32'h2572);
    wr(sbsc_pkg::ADDR_BLKCTL, 32'h2);
    chk(wide_xfer, 1'b1);
    wr(sbsc_pkg::ADDR_RATE, 32'h70);
    chk({sync_enable, wide_xfer, req_ack_period}, 32'h0b);
    apb(1'b0, 12'h020, 32'h0);
    chk({rd[30:0], err}, 32'h1);
  endtask
  task automatic t_modes;
    setp(8'h04);
    for (int m = 0; m < 4; m++)
    begin
      wr(sbsc_pkg::ADDR_MODE, 32'(m));
      wr(sbsc_pkg::ADDR_SIGNAL, 32'hff);
      chk(bus_line_o, GATE[m]);
    end
    wr(sbsc_pkg::ADDR_SIGNAL, 32'hf7);
    chk(bus_line_o, 8'he6);
  endtask
  task automatic t_atn_led;
    wr(sbsc_pkg::ADDR_MODE, 32'h2);
    wr(sbsc_pkg::ADDR_INTCLR, 32'h40);
    wr(sbsc_pkg::ADDR_SIGNAL, 32'h10);
    chk(bus_line_o, 8'h10);
    wr(sbsc_pkg::ADDR_SIGNAL, 32'h0);
    chk(bus_line_o, 8'h10);
    wr(sbsc_pkg::ADDR_INTCLR, 32'h40);
    chk(bus_line_o, 8'h00);
    wr(sbsc_pkg::ADDR_SIGNAL, 32'h4);
    chk(led_o, 1'b1);
    wr(sbsc_pkg::ADDR_BLKCTL, 32'h80);
    chk(led_o, 1'b0);
    setp(8'ha4);
    wr(sbsc_pkg::ADDR_SIGNAL, 32'ha4);
    chk({phase_match, bus_line_o}, 32'h104);
    setp(8'h64);
    chk(phase_match, 1'b0);
  endtask
  task automatic t_free;
    wr(sbsc_pkg::ADDR_MODE, 32'h1);
    wr(sbsc_pkg::ADDR_SIGNAL, 32'h2);
    chk(bus_line_o, 8'h02);
    setp(8'h00);
    chk(bus_line_o, 8'h00);
    setp(8'h04);
    wr(sbsc_pkg::ADDR_SIGNAL, 32'h6);
    chk(bus_line_o, 8'h06);
    @(posedge pclk);
    bus_reset_i <= 1'b1;
    @(posedge pclk);
    bus_reset_i <= 1'b0;
    @(negedge pclk);
    chk(bus_line_o, 8'h00);
  endtask
  initial
  begin
    {psel, penable, pwrite, bus_reset_i, presetn, paddr, pwdata, peer_lines} = '0;
    err_count = 0;
    compares = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk({bus_line_oe_n, req_ack_period}, 32'hff4);
    t_sample();
    t_rate();
    t_modes();
    t_atn_led();
    t_free();
    final_report();
  end
endmodule // tb_top
`default_nettype wire
